// >>> hw/line_cfg_pkg.sv
// Purpose: shared constants and types for the line transceiver register set
// Assumes: 16-bit monitor messages arrive as whole words from a message framer
// Notes:
package line_cfg_pkg;
	// ----------------------------------------
	// message layout
	// ----------------------------------------
	localparam logic [3:0] LOCAL_CODE    = 4'h8;
	localparam logic [3:0] ADDR_READ     = 4'h0;
	localparam logic [3:0] ADDR_GEN_CFG  = 4'h1;
	localparam logic [3:0] ADDR_LINE_CFG = 4'h2;
	localparam logic [3:0] ADDR_TEST_LO  = 4'h8;
	localparam logic [3:0] ADDR_TEST_HI  = 4'hb;
	// ----------------------------------------
	// reset values and fields
	// ----------------------------------------
	localparam logic [7:0] GEN_CFG_RST_HI  = 8'hff;
	localparam logic [7:0] GEN_CFG_RST_LO  = 8'h01;
	localparam logic [7:0] LINE_CFG_RST_HI = 8'h00;
	localparam logic [7:0] LINE_CFG_RST_LO = 8'h20;
	localparam logic [7:0] ERR_RST         = 8'h00;
	localparam logic [7:0] LINE_CFG_WMASK  = 8'he0;
	localparam int         BIT_MASK        = 0;
	localparam int         BIT_SYNC_EN     = 7;
	localparam int         BIT_BAL_EN      = 6;
	localparam int         BIT_EQ_DIS      = 5;

	typedef struct packed {
		logic [3:0] code;
		logic [3:0] addr;
		logic [7:0] data;
	} mon_msg_t;

	typedef struct packed {
		logic       superframe_sync_enable;
		logic       balance_bit_enable;
		logic       equalizer_disable;
	} line_ctl_t;
endpackage

// >>> hw/err_flag_bit.sv
// Purpose: one sticky line error flag, cleared by a register read
// Assumes: error pulses are on i_clk already
// Notes: set beats clear in the same cycle
`timescale 1ns/10ps
module err_flag_bit (
	input  wire logic i_clk,
	input  wire logic i_rst,
	input  wire logic i_ce,
	input  wire logic i_set,
	input  wire logic i_clr,
	output logic      o_flag
);
	always_ff @(posedge i_clk) begin
		if (i_rst)
			o_flag <= 1'b0;
		else if (i_ce) begin
			// a fresh error outlives the read that clears the old one
			if (i_set)
				o_flag <= 1'b1;
			else if (i_clr)
				o_flag <= 1'b0;
		end
	end
endmodule // err_flag_bit

// >>> hw/line_transceiver_config_regs.sv
// Purpose: local configuration and status registers behind the monitor channel
// Assumes: one message per i_msg_valid pulse; answers leave via o_tx_valid/i_tx_ready
// Notes: mode pin is caught on the first enabled cycle after reset release
`timescale 1ns/10ps
module line_transceiver_config_regs #(
	parameter int LINES = 8
) (
	input  wire logic                   i_clk,
	input  wire logic                   i_rst,
	input  wire logic                   i_ce,
	input  wire logic                   i_mode,
	input  wire logic                   i_frame_corrupt,
	input  wire logic                   i_msg_valid,
	input  wire line_cfg_pkg::mon_msg_t i_msg,
	input  wire logic                   i_tx_ready,
	input  wire logic [LINES-1:0]       i_line_error,
	input  wire logic                   i_superframe_sync_input_n,
	output logic                        o_tx_valid,
	output line_cfg_pkg::mon_msg_t      o_tx_msg,
	output logic [7:1]                  o_highway_channel_disable,
	output line_cfg_pkg::line_ctl_t     o_line_ctl,
	output logic                        o_force_t_bit
);
	// the error register is one byte, so exactly eight lines fit
	if (LINES != 8) begin : g_bad_lines
		$error("line count must be 8 to fit the 8-bit error register");
	end

	// ----------------------------------------
	// pin synchronisers and mode capture
	// ----------------------------------------
	logic [1:0] mode_sync_reg;
	logic [1:0] fc_sync_reg;
	logic [1:0] ss_sync_reg;
	logic       mode_reg;
	logic       mode_valid_reg;

	// no reset: pins keep sampling so the true mode is in the flops at release
	always_ff @(posedge i_clk) begin
		if (i_ce) begin
			mode_sync_reg <= {mode_sync_reg[0], i_mode};
			fc_sync_reg   <= {fc_sync_reg[0], i_frame_corrupt};
			ss_sync_reg   <= {ss_sync_reg[0], i_superframe_sync_input_n};
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			mode_reg       <= 1'b1;
			mode_valid_reg <= 1'b0;
		end else if (i_ce && !mode_valid_reg) begin
			mode_reg       <= mode_sync_reg[1];
			mode_valid_reg <= 1'b1;
		end
	end

	// ----------------------------------------
	// message decode
	// ----------------------------------------
	logic       is_local;
	logic       is_read;
	logic       wr_gen;
	logic       wr_line;
	logic       rd_err;
	logic       reinit;
	logic       tx_busy;

	assign is_local = i_ce && i_msg_valid && (i_msg.code == line_cfg_pkg::LOCAL_CODE);
	assign is_read  = is_local && (i_msg.addr == line_cfg_pkg::ADDR_READ)
		&& (i_msg.data[7:4] == 4'h0);
	assign wr_gen   = is_local && (i_msg.addr == line_cfg_pkg::ADDR_GEN_CFG);
	assign wr_line  = is_local && (i_msg.addr == line_cfg_pkg::ADDR_LINE_CFG);
	// reads need a free answer slot; a read while busy is dropped
	assign rd_err   = is_read && !tx_busy
		&& (i_msg.data[3:0] == line_cfg_pkg::ADDR_GEN_CFG);
	// re-init both at reset release (mode known) and on a corrupt frame
	assign reinit   = i_ce && (!mode_valid_reg || fc_sync_reg[1]);

	// ----------------------------------------
	// writable registers
	// ----------------------------------------
	logic [7:0] gen_cfg_reg;
	logic [7:0] line_cfg_reg;
	logic       mode_now;

	assign mode_now = mode_valid_reg ? mode_reg : mode_sync_reg[1];

	always_ff @(posedge i_clk) begin
		if (i_rst)
			gen_cfg_reg <= line_cfg_pkg::GEN_CFG_RST_HI;
		else if (reinit)
			gen_cfg_reg <= mode_now ? line_cfg_pkg::GEN_CFG_RST_HI
				: line_cfg_pkg::GEN_CFG_RST_LO;
		else if (wr_gen)
			gen_cfg_reg <= i_msg.data;
	end

	always_ff @(posedge i_clk) begin
		if (i_rst)
			line_cfg_reg <= line_cfg_pkg::LINE_CFG_RST_HI;
		else if (reinit)
			line_cfg_reg <= mode_now ? line_cfg_pkg::LINE_CFG_RST_HI
				: line_cfg_pkg::LINE_CFG_RST_LO;
		else if (wr_line)
			line_cfg_reg <= i_msg.data & line_cfg_pkg::LINE_CFG_WMASK;
	end

	// ----------------------------------------
	// error flags, one sticky bit per line
	// ----------------------------------------
	logic [7:0] err_flags;
	logic       auto_send;

	generate
		for (genvar n = 0; n < LINES; n++) begin : g_flag
			err_flag_bit u_flag (
				.i_clk  (i_clk),
				.i_rst  (i_rst),
				.i_ce   (i_ce),
				.i_set  (i_line_error[n]),
				.i_clr  (rd_err || auto_send),
				.o_flag (err_flags[n])
			);
		end
	endgenerate

	// ----------------------------------------
	// answer and unsolicited report
	// ----------------------------------------
	// reports count as a read so each error is reported once
	assign auto_send = i_ce && !tx_busy && !is_read
		&& !gen_cfg_reg[line_cfg_pkg::BIT_MASK] && (err_flags != 8'h00);
	assign tx_busy   = o_tx_valid && !i_tx_ready;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_tx_valid <= 1'b0;
			o_tx_msg   <= '0;
		end else if (i_ce) begin
			if (is_read && !tx_busy) begin
				o_tx_valid    <= 1'b1;
				o_tx_msg.code <= line_cfg_pkg::LOCAL_CODE;
				o_tx_msg.addr <= i_msg.data[3:0];
				// write-only and unknown addresses answer zero
				o_tx_msg.data <= rd_err ? err_flags : 8'h00;
			end else if (auto_send) begin
				o_tx_valid    <= 1'b1;
				o_tx_msg.code <= line_cfg_pkg::LOCAL_CODE;
				o_tx_msg.addr <= line_cfg_pkg::ADDR_GEN_CFG;
				o_tx_msg.data <= err_flags;
			end else if (i_tx_ready)
				o_tx_valid <= 1'b0;
		end
	end

	// ----------------------------------------
	// control outputs
	// ----------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_highway_channel_disable <= line_cfg_pkg::GEN_CFG_RST_HI[7:1];
			o_line_ctl                <= '0;
			o_force_t_bit             <= 1'b0;
		end else if (i_ce) begin
			o_highway_channel_disable <= gen_cfg_reg[7:1];
			o_line_ctl.superframe_sync_enable <= line_cfg_reg[line_cfg_pkg::BIT_SYNC_EN];
			o_line_ctl.balance_bit_enable <= line_cfg_reg[line_cfg_pkg::BIT_BAL_EN];
			o_line_ctl.equalizer_disable <= line_cfg_reg[line_cfg_pkg::BIT_EQ_DIS];
			o_force_t_bit <= line_cfg_reg[line_cfg_pkg::BIT_SYNC_EN]
				&& !ss_sync_reg[1];
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	sequence s_write_gen;
		i_ce && i_msg_valid && i_msg.code == 4'h8 && i_msg.addr == 4'h1 && !reinit;
	endsequence

	sequence s_answer_wait;
		i_ce && o_tx_valid && !i_tx_ready;
	endsequence

	a_gen_write_lands: assert property (s_write_gen |=> gen_cfg_reg == $past(i_msg.data))
		else $error("general config write lost");
	a_chan_disable_out: assert property (s_write_gen ##1 i_ce |=>
		o_highway_channel_disable == $past(gen_cfg_reg[7:1]))
		else $error("channel disable not following register");
	a_line_low_zero: assert property (line_cfg_reg[4:0] == 5'h00)
		else $error("line config low bits not zero");
	a_mask_silences: assert property (i_ce && gen_cfg_reg[0] && !is_read && !tx_busy
		|=> !o_tx_valid || $past(o_tx_valid))
		else $error("unsolicited report while masked");
	a_report_sent: assert property (i_ce && !tx_busy && !is_read && !gen_cfg_reg[0]
		&& err_flags != 8'h00 |=> o_tx_valid && o_tx_msg.data != 8'h00)
		else $error("nonzero error flags not reported");
	a_read_clears: assert property (rd_err && i_line_error == 8'h00 |=> err_flags == 8'h00)
		else $error("error flags not cleared by read");
	a_read_answer: assert property (rd_err |=> o_tx_valid && o_tx_msg.addr == 4'h1
		&& o_tx_msg.data == $past(err_flags))
		else $error("read answer wrong");
	a_flag_sticky: assert property (i_ce && i_line_error[0] |=> err_flags[0])
		else $error("error event lost");
	a_corrupt_reinit: assert property (i_ce && fc_sync_reg[1] && mode_valid_reg && mode_reg
		|=> gen_cfg_reg == 8'hff && line_cfg_reg == 8'h00)
		else $error("corrupt frame did not restore registers");
	a_tbit_force: assert property (i_ce && line_cfg_reg[7] && !ss_sync_reg[1] |=> o_force_t_bit)
		else $error("T bit not forced");
	a_flag_held: assert property (i_ce && err_flags != 8'h00 && !rd_err && !auto_send
		|=> (err_flags & $past(err_flags)) == $past(err_flags))
		else $error("error flag dropped without a read");
	a_answer_held: assert property (s_answer_wait |=> o_tx_valid && $stable(o_tx_msg))
		else $error("answer changed before it was taken");
	a_ce_freeze: assert property (!i_ce |=> $stable(gen_cfg_reg) && $stable(line_cfg_reg)
		&& $stable(err_flags) && $stable(o_tx_valid))
		else $error("state moved while clock enable low");
endmodule // line_transceiver_config_regs

// >>> verification/ctl_model.sv
// Purpose: behavioural layer-2 controller on the monitor channel
// Assumes: driven after each rising edge by the same 1 ns delay
// Notes: stall sets how many cycles an answer waits for ready
`timescale 1ns/10ps
module ctl_model (
	input  wire logic                   i_clk,
	input  wire logic                   i_tx_valid,
	input  wire line_cfg_pkg::mon_msg_t i_tx_msg,
	output logic                        o_msg_valid = 0,
	output line_cfg_pkg::mon_msg_t      o_msg = '0,
	output logic                        o_tx_ready = 0
);
	line_cfg_pkg::mon_msg_t rx;
	int                     n_rx = 0;
	int                     stall = 0;
	int                     cnt = 0;

	// one word per message, test addresses never sent
	task automatic send(input logic [15:0] m);
		o_msg = m;
		o_msg_valid = 1;
		@(posedge i_clk);
		#1 o_msg_valid = 0;
		// released bus shows garbage, not the old word
		o_msg = ~m;
		@(posedge i_clk);
		#1;
	endtask

	always @(posedge i_clk) begin
		if (i_tx_valid && o_tx_ready) begin
			rx = i_tx_msg;
			n_rx++;
		end
		#1;
		cnt = i_tx_valid ? cnt + 1 : 0;
		o_tx_ready = i_tx_valid && cnt > stall;
	end
endmodule // ctl_model

// >>> verification/tb.sv
// Purpose: self-checking bench for the line transceiver registers
// Assumes: ctl_model speaks the monitor channel
// Notes: random data from an xorshift seeded with 13886
`timescale 1ns/10ps
`define CHK(nm, e, s) begin tests_run++; if ((s) !== (e)) begin n_mismatch++; \
	$display("mismatch %s exp %h got %h", nm, e, s); end end
module tb;
	logic                    i_clk = 0;
	logic                    i_rst = 1;
	logic                    i_ce = 1;
	logic                    i_mode = 1;
	logic                    i_frame_corrupt = 0;
	logic [7:0]              i_line_error = 0;
	logic                    i_superframe_sync_input_n = 1;
	logic                    msg_valid, tx_ready, tx_valid, force_t;
	line_cfg_pkg::mon_msg_t  msg, tx_msg;
	logic [7:1]              chdis;
	line_cfg_pkg::line_ctl_t lctl;
	logic [31:0]             seed = 32'h0000363e;
	logic [7:0]              v, e1, e2;
	int                      n_mismatch = 0;
	int                      tests_run = 0;
	int                      n;

	line_transceiver_config_regs DUT (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce),
		.i_mode(i_mode), .i_frame_corrupt(i_frame_corrupt), .i_msg_valid(msg_valid),
		.i_msg(msg), .i_tx_ready(tx_ready), .i_line_error(i_line_error),
		.i_superframe_sync_input_n(i_superframe_sync_input_n), .o_tx_valid(tx_valid),
		.o_tx_msg(tx_msg), .o_highway_channel_disable(chdis), .o_line_ctl(lctl),
		.o_force_t_bit(force_t));
	ctl_model u_ctl (.i_clk(i_clk), .i_tx_valid(tx_valid), .i_tx_msg(tx_msg),
		.o_msg_valid(msg_valid), .o_msg(msg), .o_tx_ready(tx_ready));

	always #20 i_clk = ~i_clk;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	function logic [15:0] ans(input logic [3:0] a, input logic [7:0] d);
		return {line_cfg_pkg::LOCAL_CODE, a, d};
	endfunction
	task automatic cyc(input int c);
		repeat (c) @(posedge i_clk);
		#1;
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		u_ctl.send({line_cfg_pkg::LOCAL_CODE, a, d});
		cyc(1);
	endtask
	// bounded wait: a lost answer must not hang the run
	task automatic wait_rx(input int c);
		for (int k = 0; k < 20 && u_ctl.n_rx == c; k++) cyc(1);
		`CHK("answers", c + 1, u_ctl.n_rx)
	endtask
	task automatic rd(input logic [3:0] a);
		n = u_ctl.n_rx;
		u_ctl.send({line_cfg_pkg::LOCAL_CODE, line_cfg_pkg::ADDR_READ, 4'h0, a});
		wait_rx(n);
	endtask
	task automatic test_done();
		if (n_mismatch == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial begin
		#80000;
		n_mismatch++;
		test_done();
	end

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		cyc(5);
		i_rst = 0;
		cyc(3);
		`CHK("chdis", 7'h7f, chdis)
		`CHK("lctl", 3'b000, lctl)
		repeat (4) begin
			v = rnd() | 8'h01;
			wr(line_cfg_pkg::ADDR_GEN_CFG, v);
			`CHK("chdis", v[7:1], chdis)
			wr(line_cfg_pkg::ADDR_LINE_CFG, v);
			`CHK("lctl", v[7:5], lctl)
			u_ctl.send({1'b0, v[2:0], line_cfg_pkg::ADDR_GEN_CFG, ~v});
			cyc(1);
			`CHK("chdis", v[7:1], chdis)
		end
		i_ce = 0;
		wr(line_cfg_pkg::ADDR_GEN_CFG, ~v);
		i_ce = 1;
		`CHK("chdis", v[7:1], chdis)
		wr(line_cfg_pkg::ADDR_LINE_CFG, 8'h80);
		i_superframe_sync_input_n = 0;
		cyc(5);
		`CHK("force", 1'b1, force_t)
		wr(line_cfg_pkg::ADDR_LINE_CFG, 8'h40);
		cyc(4);
		`CHK("force", 1'b0, force_t)
		i_superframe_sync_input_n = 1;
		wr(line_cfg_pkg::ADDR_GEN_CFG, 8'h01);
		n = u_ctl.n_rx;
		e1 = rnd() | 8'h01;
		e2 = rnd();
		i_line_error = e1;
		cyc(1);
		i_line_error = 0;
		cyc(2);
		i_line_error = e2;
		cyc(1);
		i_line_error = 0;
		cyc(4);
		`CHK("reports", n, u_ctl.n_rx)
		u_ctl.stall = 3;
		rd(line_cfg_pkg::ADDR_GEN_CFG);
		`CHK("rx", ans(4'h1, e1 | e2), u_ctl.rx)
		u_ctl.stall = 0;
		rd(line_cfg_pkg::ADDR_GEN_CFG);
		`CHK("rx", ans(4'h1, 8'h00), u_ctl.rx)
		wr(line_cfg_pkg::ADDR_GEN_CFG, 8'h00);
		i_frame_corrupt = 1;
		cyc(4);
		i_frame_corrupt = 0;
		cyc(4);
		`CHK("chdis", 7'h7f, chdis)
		`CHK("lctl", 3'b000, lctl)
		i_mode = 0;
		i_rst = 1;
		cyc(5);
		i_rst = 0;
		cyc(3);
		`CHK("chdis", 7'h00, chdis)
		`CHK("lctl", 3'b001, lctl)
		// mode low leaves the report mask set, so open it first
		wr(line_cfg_pkg::ADDR_GEN_CFG, 8'h00);
		n = u_ctl.n_rx;
		e1 = rnd() | 8'h80;
		i_line_error = e1;
		cyc(1);
		i_line_error = 0;
		wait_rx(n);
		`CHK("rx", ans(4'h1, e1), u_ctl.rx)
		test_done();
	end
endmodule // tb
